// ===== rtl/touch_regs_pkg.sv
// Constants shared by the touch controller host register bank.
// Assumes a register port fed by the serial slave front end on the same clock.
package touch_regs_pkg;

   // ----------------------------------------------------------------
   // Register offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_INTERRUPT_SOURCE = 8'h00;
   localparam logic [7:0] ADDR_OP_MODE_COMP = 8'h09;
   localparam logic [7:0] ADDR_OUTPUT_ON_OFF = 8'h0a;
   localparam logic [7:0] ADDR_PWM_PIN_SELECT = 8'h0b;
   localparam logic [7:0] ADDR_PWM_PIN_LEVEL = 8'h0c;
   localparam logic [7:0] ADDR_GATEWAY_CFG = 8'h0d;
   localparam logic [7:0] ADDR_GATEWAY_BASE = 8'h0e;
   localparam logic [7:0] ADDR_KEY_HI = 8'hac;
   localparam logic [7:0] ADDR_KEY_LO = 8'had;
   localparam logic [7:0] ADDR_CHIP_RESET = 8'hb1;

   // ----------------------------------------------------------------
   // Field positions and codes
   // ----------------------------------------------------------------
   localparam int COMP_BIT = 2;
   localparam int MODE_LSB = 0;
   localparam int IF_MODE_LSB = 4;
   localparam int DIR_BIT = 3;
   localparam int FLAG_MODE = 0;
   localparam int FLAG_COMP = 1;
   localparam int FLAG_PARAM_WR = 5;
   localparam int WR_DONE_BIT = 6;

   typedef enum logic [1:0] {
      OPM_ACTIVE = 2'h0,
      OPM_DOZE = 2'h1,
      OPM_SLEEP = 2'h2,
      OPM_RESERVED = 2'h3
   } op_mode_t;

   localparam logic [1:0] IF_NORMAL = 2'h0;
   localparam logic [1:0] IF_PARAM = 2'h1;

   // ----------------------------------------------------------------
   // Reset values, keys and sizes
   // ----------------------------------------------------------------
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam logic [2:0] PIN_SEL_RESET = 3'h0;
   localparam logic [7:0] BASE_RESET = 8'h00;
   localparam logic [7:0] BASE_MAX = 8'h78;
   localparam logic [7:0] BASE_ALIGN_MASK = 8'h78;
   localparam logic [7:0] RESET_KEY_FIRST = 8'hde;
   localparam logic [7:0] RESET_KEY_SECOND = 8'h00;
   localparam logic [7:0] BURN_KEY_HI = 8'h62;
   localparam logic [7:0] BURN_KEY_LO = 8'h9d;
   localparam logic [7:0] BURST_LAST = 8'h07;
   localparam logic [7:0] BURST_FULL_MASK = 8'hff;
   localparam int NUM_PINS = 8;

endpackage

// ===== rtl/touch_ctrl_spm_gateway_regs.sv
// Host register bank of the touch controller: mode and compensation control,
// plain output on/off control, per-pin PWM intensity, chip reset trigger,
// and the gateway into the shadow parameter memory.
// Assumes a serial slave front end that presents one decoded register access
// per strobe, and a parameter memory that answers a read within the cycle
// in which its registered address and read strobe stand, both on clk.
//
// Notes on behaviour
// RULE_01: Host writes zeros to mode register bits 7:3; reads may return anything.
// RULE_02: Mode register bit 2 reads 1 while compensating; writing 1 starts one.
// RULE_03: Mode field 00 active after reset, 01 doze, 10 sleep, 11 reserved.
// RULE_04: After asking for active or doze, host waits for interrupt or 300 ms.
// RULE_05: With automatic lighting off, output bits pick on or off intensity.
// RULE_06: Output control bits of pins that are not plain outputs are ignored.
// RULE_07: Output control register resets from the power-up output state parameter.
// RULE_08: Three-bit selector picks which PWM pin intensity accesses use; resets to 0.
// RULE_09: Intensity write sets selected pin index 0 to 255; read returns it.
// RULE_10: After power-up each PWM index equals on or off intensity per parameter.
// RULE_11: Write 0xDE then immediately 0x00 to the reset register resets the chip.
// RULE_12: Gateway bits 5:4 choose normal (reset) or parameter memory mode.
// RULE_13: Gateway bit 3 chooses direction: 0 write after reset, 1 read.
// RULE_14: Gateway base is a multiple of eight from 0x00 to 0x78; resets 0x00.
// RULE_15: Every parameter memory transfer moves exactly eight bytes from the base; the bank passes each byte on alone and only withholds the commit pulse.
// RULE_16: Burn unlocks only after high key 0x62 and low key 0x9D are written.
// RULE_17: Block write: mode, base, eight bytes at 0 to 7, then 000 to bits 5:3.
// RULE_18: Whole memory is written by sixteen block writes with bases 0x00 to 0x78.
// RULE_19: An effective block write asserts the active-low interrupt output.
// RULE_20: Any host read clears the write interrupt and the write-done status bit.
// RULE_21: Parameter write interrupt flag, bit 5, sets when a block write takes effect.
// RULE_22: Compensation flag, bit 1, sets whenever a compensation procedure finishes.
// RULE_23: Mode flag, bit 0, sets on actually entering active or doze on request.
// RULE_24: In parameter mode addresses 0 to 7 reach memory at base plus offset.
// RULE_25: Reserved gateway bits 7:6 and 2:0 ignore writes and stay zero.
`timescale 1ns/1ps

module touch_ctrl_spm_gateway_regs (
   input wire logic clk,
   input wire logic srst,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   output logic reg_rvalid,
   output logic [7:0] spm_addr,
   output logic [7:0] spm_wdata,
   output logic spm_we,
   output logic spm_re,
   input wire logic [7:0] spm_rdata,
   output logic spm_block_commit,
   input wire logic [7:0] powerup_output_state,
   input wire logic [7:0] on_level,
   input wire logic [7:0] off_level,
   input wire logic [7:0] plain_output_pin,
   input wire logic autolight_en,
   output logic [1:0] op_mode,
   output logic mode_change_req,
   input wire logic mode_entered,
   output logic comp_start,
   input wire logic comp_done,
   output logic [63:0] pwm_level,
   output logic burn_unlocked,
   output logic chip_reset,
   output logic [7:0] interrupt_source,
   output logic write_done,
   output logic irq_n
);
   import touch_regs_pkg::*;

   // ----------------------------------------------------------------
   // Access decode
   // ----------------------------------------------------------------
   function automatic logic hit(input logic [7:0] a, input logic [7:0] ref_a);
      hit = (a == ref_a);
   endfunction

   op_mode_t mode_r;
   logic comp_busy_r;
   logic mode_req_pend_r;
   logic [7:0] gpo_ctrl_r;
   logic [2:0] pin_sel_r;
   logic [7:0] level_r [NUM_PINS];
   logic [1:0] if_mode_r;
   logic dir_rd_r;
   logic [7:0] base_r;
   logic [7:0] key_hi_r;
   logic [7:0] key_lo_r;
   logic reset_armed_r;
   logic [7:0] burst_seen_r;
   logic [7:0] flags_r;
   logic wr_done_r;
   logic rd_pend_r;
   logic rd_from_spm_r;
   logic [7:0] rd_stage_r;
   logic in_param_win;
   logic param_wr;
   logic param_rd;
   logic reg_wr_n;
   logic reg_rd_n;
   logic gw_end_wr;
   logic [7:0] rd_mux;

   // Rule 24 window: only offsets 0 to 7 divert while parameter mode is on.
   // RULE_24: gateway address window
   assign in_param_win = (if_mode_r == IF_PARAM) && (reg_addr <= BURST_LAST);
   assign param_wr = reg_wr && in_param_win && !dir_rd_r;
   assign param_rd = reg_rd && in_param_win && dir_rd_r;
   assign reg_wr_n = reg_wr && !in_param_win;
   assign reg_rd_n = reg_rd && !in_param_win;
   assign gw_end_wr = reg_wr_n && hit(reg_addr, ADDR_GATEWAY_CFG)
      && (reg_wdata[5:3] == 3'h0);

   // ----------------------------------------------------------------
   // Operating mode and compensation
   // ----------------------------------------------------------------
   // RULE_01: reserved bits dropped
   // RULE_03: mode field select
   always_ff @(posedge clk) begin
      if (srst) begin
         mode_r <= OPM_ACTIVE;
         mode_req_pend_r <= 1'b0;
         mode_change_req <= 1'b0;
      end else begin
         mode_change_req <= 1'b0;
         if (reg_wr_n && hit(reg_addr, ADDR_OP_MODE_COMP)
               && (op_mode_t'(reg_wdata[MODE_LSB +: 2]) != OPM_RESERVED)) begin
            mode_r <= op_mode_t'(reg_wdata[MODE_LSB +: 2]);
            mode_change_req <= 1'b1;
            mode_req_pend_r <= (op_mode_t'(reg_wdata[MODE_LSB +: 2]) != OPM_SLEEP);
         end else if (mode_entered) begin
            mode_req_pend_r <= 1'b0;
         end
      end
   end

   // RULE_02: compensation start and busy
   always_ff @(posedge clk) begin
      if (srst) begin
         comp_busy_r <= 1'b0;
         comp_start <= 1'b0;
      end else begin
         comp_start <= reg_wr_n && hit(reg_addr, ADDR_OP_MODE_COMP) && reg_wdata[COMP_BIT];
         if (reg_wr_n && hit(reg_addr, ADDR_OP_MODE_COMP) && reg_wdata[COMP_BIT]) begin
            comp_busy_r <= 1'b1;
         end else if (comp_done) begin
            comp_busy_r <= 1'b0;
         end
      end
   end

   assign op_mode = mode_r;

   // ----------------------------------------------------------------
   // Outputs: on/off control, pin selector, intensities
   // ----------------------------------------------------------------
   // RULE_07: reset from power-up state
   always_ff @(posedge clk) begin
      if (srst) begin
         gpo_ctrl_r <= powerup_output_state;
      end else if (reg_wr_n && hit(reg_addr, ADDR_OUTPUT_ON_OFF)) begin
         gpo_ctrl_r <= reg_wdata;
      end
   end

   // RULE_08: pin selector
   always_ff @(posedge clk) begin
      if (srst) begin
         pin_sel_r <= PIN_SEL_RESET;
      end else if (reg_wr_n && hit(reg_addr, ADDR_PWM_PIN_SELECT)) begin
         pin_sel_r <= reg_wdata[2:0];
      end
   end

   // A host intensity write and an on/off write in the same cycle cannot
   // happen, since the front end presents one access at a time.
   for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
      always_ff @(posedge clk) begin
         if (srst) begin
            // RULE_10: power-up intensity choice
            level_r[i] <= powerup_output_state[i] ? on_level : off_level;
         end else if (reg_wr_n && hit(reg_addr, ADDR_PWM_PIN_LEVEL)
               && (pin_sel_r == 3'(i))) begin
            // RULE_09: intensity write
            level_r[i] <= reg_wdata;
         end else if (reg_wr_n && hit(reg_addr, ADDR_OUTPUT_ON_OFF)
               && !autolight_en && plain_output_pin[i]) begin
            // RULE_05: on/off drives intensity
            // RULE_06: non-output pins ignored
            level_r[i] <= reg_wdata[i] ? on_level : off_level;
         end
      end
      assign pwm_level[8 * i +: 8] = level_r[i];
   end

   // ----------------------------------------------------------------
   // Chip reset trigger and burn keys
   // ----------------------------------------------------------------
   // RULE_11: two-write reset sequence
   always_ff @(posedge clk) begin
      if (srst) begin
         reset_armed_r <= 1'b0;
         chip_reset <= 1'b0;
      end else begin
         chip_reset <= reg_wr_n && hit(reg_addr, ADDR_CHIP_RESET) && reset_armed_r
            && (reg_wdata == RESET_KEY_SECOND);
         if (reg_wr) begin
            reset_armed_r <= reg_wr_n && hit(reg_addr, ADDR_CHIP_RESET)
               && (reg_wdata == RESET_KEY_FIRST);
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         key_hi_r <= BYTE_ZERO;
         key_lo_r <= BYTE_ZERO;
      end else begin
         if (reg_wr_n && hit(reg_addr, ADDR_KEY_HI)) begin
            key_hi_r <= reg_wdata;
         end
         if (reg_wr_n && hit(reg_addr, ADDR_KEY_LO)) begin
            key_lo_r <= reg_wdata;
         end
      end
   end

   // RULE_16: burn unlock keys
   always_ff @(posedge clk) begin
      if (srst) begin
         burn_unlocked <= 1'b0;
      end else begin
         burn_unlocked <= (key_hi_r == BURN_KEY_HI) && (key_lo_r == BURN_KEY_LO);
      end
   end

   // ----------------------------------------------------------------
   // Parameter memory gateway
   // ----------------------------------------------------------------
   // RULE_12: interface mode select
   // RULE_13: direction select
   // RULE_25: reserved bits held zero
   always_ff @(posedge clk) begin
      if (srst) begin
         if_mode_r <= IF_NORMAL;
         dir_rd_r <= 1'b0;
      end else if (reg_wr_n && hit(reg_addr, ADDR_GATEWAY_CFG)) begin
         if_mode_r <= reg_wdata[IF_MODE_LSB +: 2];
         dir_rd_r <= reg_wdata[DIR_BIT];
      end
   end

   // The low three bits are dropped so that a burst can never straddle
   // two blocks; values past the top are clamped to the last block.
   // RULE_14: aligned base
   always_ff @(posedge clk) begin
      if (srst) begin
         base_r <= BASE_RESET;
      end else if (reg_wr_n && hit(reg_addr, ADDR_GATEWAY_BASE)) begin
         base_r <= (reg_wdata > BASE_MAX) ? BASE_MAX : (reg_wdata & BASE_ALIGN_MASK);
      end
   end

   // RULE_15: eight-byte burst tracking
   // RULE_17: block terminated by 000
   always_ff @(posedge clk) begin
      if (srst) begin
         burst_seen_r <= BYTE_ZERO;
         spm_block_commit <= 1'b0;
      end else begin
         spm_block_commit <= gw_end_wr && (burst_seen_r == BURST_FULL_MASK);
         if (gw_end_wr || (reg_wr_n && hit(reg_addr, ADDR_GATEWAY_BASE))) begin
            burst_seen_r <= BYTE_ZERO;
         end else if (param_wr) begin
            burst_seen_r[reg_addr[2:0]] <= 1'b1;
         end
      end
   end

   // Memory side: one strobe per byte, address already offset from base.
   // RULE_24: base plus offset
   always_ff @(posedge clk) begin
      if (srst) begin
         spm_addr <= BYTE_ZERO;
         spm_wdata <= BYTE_ZERO;
         spm_we <= 1'b0;
         spm_re <= 1'b0;
      end else begin
         spm_we <= param_wr;
         spm_re <= param_rd;
         if (param_wr || param_rd) begin
            spm_addr <= base_r | {5'h0, reg_addr[2:0]};
            spm_wdata <= reg_wdata;
         end
      end
   end

   // ----------------------------------------------------------------
   // Event flags and interrupt line
   // ----------------------------------------------------------------
   // A set in the same cycle as a read-clear wins, so no event is lost.
   always_ff @(posedge clk) begin
      if (srst) begin
         flags_r <= BYTE_ZERO;
         wr_done_r <= 1'b0;
      end else begin
         // RULE_20: read clears write flag
         if (reg_rd) begin
            flags_r[FLAG_PARAM_WR] <= 1'b0;
            wr_done_r <= 1'b0;
         end
         if (reg_rd_n && hit(reg_addr, ADDR_INTERRUPT_SOURCE)) begin
            flags_r[FLAG_MODE] <= 1'b0;
            flags_r[FLAG_COMP] <= 1'b0;
         end
         // RULE_21: parameter write flag
         if (spm_block_commit) begin
            flags_r[FLAG_PARAM_WR] <= 1'b1;
            wr_done_r <= 1'b1;
         end
         // RULE_22: compensation flag
         if (comp_done) begin
            flags_r[FLAG_COMP] <= 1'b1;
         end
         // RULE_23: mode flag
         if (mode_entered && mode_req_pend_r) begin
            flags_r[FLAG_MODE] <= 1'b1;
         end
      end
   end

   // RULE_19: active-low interrupt
   always_ff @(posedge clk) begin
      if (srst) begin
         irq_n <= 1'b1;
      end else begin
         irq_n <= !(|flags_r);
      end
   end

   assign interrupt_source = flags_r;
   assign write_done = wr_done_r;

   // ----------------------------------------------------------------
   // Read path
   // ----------------------------------------------------------------
   // All reads answer two cycles after the strobe so that memory reads
   // and register reads share one latency.
   always_comb begin
      rd_mux = BYTE_ZERO;
      unique case (1'b1)
         hit(reg_addr, ADDR_INTERRUPT_SOURCE): rd_mux = flags_r;
         hit(reg_addr, ADDR_OP_MODE_COMP): rd_mux = {5'h0, comp_busy_r, mode_r};
         hit(reg_addr, ADDR_OUTPUT_ON_OFF): rd_mux = gpo_ctrl_r;
         hit(reg_addr, ADDR_PWM_PIN_SELECT): rd_mux = {5'h0, pin_sel_r};
         hit(reg_addr, ADDR_PWM_PIN_LEVEL): rd_mux = level_r[pin_sel_r];
         hit(reg_addr, ADDR_GATEWAY_CFG): rd_mux = {2'h0, if_mode_r, dir_rd_r, 3'h0};
         hit(reg_addr, ADDR_GATEWAY_BASE): rd_mux = base_r;
         hit(reg_addr, ADDR_KEY_HI): rd_mux = key_hi_r;
         hit(reg_addr, ADDR_KEY_LO): rd_mux = key_lo_r;
         default: rd_mux = BYTE_ZERO;
      endcase
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         rd_pend_r <= 1'b0;
         rd_from_spm_r <= 1'b0;
         rd_stage_r <= BYTE_ZERO;
         reg_rdata <= BYTE_ZERO;
         reg_rvalid <= 1'b0;
      end else begin
         rd_pend_r <= reg_rd;
         rd_from_spm_r <= param_rd;
         if (reg_rd) begin
            rd_stage_r <= in_param_win ? BYTE_ZERO : rd_mux;
         end
         reg_rvalid <= rd_pend_r;
         if (rd_pend_r) begin
            reg_rdata <= rd_from_spm_r ? spm_rdata : rd_stage_r;
         end
      end
   end

endmodule

// ===== bench/touch_core_model.sv
// Stand-in for the parameter memory and the sensing core.
// Assumes the bank's one-cycle memory read and its request pulses.
`timescale 1ns/1ps
module touch_core_model (
   input wire logic clk,
   input wire logic [7:0] spm_addr,
   input wire logic [7:0] spm_wdata,
   input wire logic spm_we,
   input wire logic spm_re,
   output logic [7:0] spm_rdata,
   input wire logic mode_change_req,
   input wire logic comp_start,
   output logic mode_entered,
   output logic comp_done
);
   logic [7:0] mem [0:127];
   logic [3:0] cq = 4'h0;
   logic [3:0] mq = 4'h0;
   logic [7:0] junk = 8'h00;
   always @(posedge clk) begin
      if (spm_we)
         mem[spm_addr[6:0]] <= spm_wdata;
      junk <= ~junk;
   end
   // Data is only good while the read strobe stands; otherwise it toggles.
   assign spm_rdata = spm_re ? mem[spm_addr[6:0]] : junk;
   always @(posedge clk) begin
      cq <= {cq[2:0], comp_start};
      mq <= {mq[2:0], mode_change_req};
   end
   assign comp_done = cq[3];
   assign mode_entered = mq[3];
endmodule

// ===== bench/touch_regs_checker.sv
// Port-level checks for the touch register bank.
// Assumes one clk domain and synchronous active-high srst.
`timescale 1ns/1ps
module touch_regs_checker (
   input wire logic clk,
   input wire logic srst,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_rvalid,
   input wire logic [7:0] spm_addr,
   input wire logic [7:0] spm_wdata,
   input wire logic spm_we,
   input wire logic spm_re,
   input wire logic spm_block_commit,
   input wire logic mode_change_req,
   input wire logic comp_start,
   input wire logic chip_reset,
   input wire logic [7:0] interrupt_source,
   input wire logic write_done,
   input wire logic irq_n
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (srst);
   sequence s_key_pair;
      reg_wr && reg_addr == 8'hb1 && reg_wdata == 8'hde ##1
      reg_wr && reg_addr == 8'hb1 && reg_wdata == 8'h00;
   endsequence
   sequence s_flags_up;
      (interrupt_source[5] && write_done) ##1 !irq_n;
   endsequence
   a_read_latency: assert property (reg_rd |-> ##2 reg_rvalid)
      else $error("read answer late");
   a_spm_byte_map: assert property (spm_we |-> $past(reg_wr) &&
      spm_addr[2:0] == $past(reg_addr[2:0]) && spm_wdata == $past(reg_wdata))
      else $error("memory write mapping wrong");
   a_base_range: assert property ((spm_we || spm_re) |-> spm_addr <= 8'h7f)
      else $error("memory address out of range");
   a_comp_start: assert property (reg_wr && reg_addr == 8'h09 && reg_wdata[2]
      |=> comp_start) else $error("compensation not started");
   a_mode_req: assert property (reg_wr && reg_addr == 8'h09 |=>
      mode_change_req == ($past(reg_wdata[1:0]) != 2'h3))
      else $error("mode request wrong");
   a_key_reset: assert property (s_key_pair |=> chip_reset)
      else $error("chip reset missing");
   a_commit_flags: assert property (spm_block_commit |=> s_flags_up)
      else $error("commit did not raise flags");
   a_irq_level: assert property (1'b1 |=> irq_n == !$past(|interrupt_source))
      else $error("interrupt line wrong");
   a_read_clears: assert property (reg_rd && !spm_block_commit |=> !write_done)
      else $error("write done not cleared");
endmodule
bind touch_ctrl_spm_gateway_regs touch_regs_checker chk_i (.clk(clk), .srst(srst),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_rvalid(reg_rvalid), .spm_addr(spm_addr), .spm_wdata(spm_wdata), .spm_we(spm_we),
   .spm_re(spm_re), .spm_block_commit(spm_block_commit), .mode_change_req(mode_change_req),
   .comp_start(comp_start), .chip_reset(chip_reset), .interrupt_source(interrupt_source),
   .write_done(write_done), .irq_n(irq_n));

// ===== bench/test_touch_ctrl_spm_gateway_regs.sv
// Self-checking bench for the touch register bank.
// Assumes the core model for memory data and completion pulses.
`timescale 1ns/1ps
module test_touch_ctrl_spm_gateway_regs;
   import touch_regs_pkg::*;
   localparam logic [7:0] PWR = 8'h96;
   localparam logic [7:0] ONL = 8'hc8;
   localparam logic [7:0] OFFL = 8'h11;
   logic clk = 1'b0, srst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, autolight_en = 1'b0;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, plain_output_pin = 8'h0f;
   logic [7:0] reg_rdata, spm_addr, spm_wdata, spm_rdata, interrupt_source;
   logic [1:0] op_mode;
   logic [63:0] pwm_level;
   logic reg_rvalid, spm_we, spm_re, spm_block_commit, mode_change_req, mode_entered;
   logic comp_start, comp_done, burn_unlocked, chip_reset, write_done, irq_n;
   int err_total = 0;
   int checks = 0;
   touch_ctrl_spm_gateway_regs dut (.clk(clk), .srst(srst), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .reg_rvalid(reg_rvalid), .spm_addr(spm_addr), .spm_wdata(spm_wdata), .spm_we(spm_we),
      .spm_re(spm_re), .spm_rdata(spm_rdata), .spm_block_commit(spm_block_commit),
      .powerup_output_state(PWR), .on_level(ONL), .off_level(OFFL),
      .plain_output_pin(plain_output_pin), .autolight_en(autolight_en), .op_mode(op_mode),
      .mode_change_req(mode_change_req), .mode_entered(mode_entered),
      .comp_start(comp_start), .comp_done(comp_done), .pwm_level(pwm_level),
      .burn_unlocked(burn_unlocked), .chip_reset(chip_reset),
      .interrupt_source(interrupt_source), .write_done(write_done), .irq_n(irq_n));
   touch_core_model pm (.clk(clk), .spm_addr(spm_addr), .spm_wdata(spm_wdata),
      .spm_we(spm_we), .spm_re(spm_re), .spm_rdata(spm_rdata),
      .mode_change_req(mode_change_req), .comp_start(comp_start),
      .mode_entered(mode_entered), .comp_done(comp_done));
   always #50 clk = ~clk;
   // ----
   // Bus tasks
   // ----
   task automatic chk(input string n, input logic [63:0] s, input logic [63:0] e);
      checks++;
      if (s !== e) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(negedge clk);
      reg_wr = 1'b0;
   endtask
   // Answer stands one cycle, two cycles after the strobe.
   task automatic rc(input logic [7:0] a, input logic [7:0] e);
      @(negedge clk);
      reg_rd = 1'b1;
      reg_addr = a;
      @(negedge clk);
      reg_rd = 1'b0;
      @(negedge clk);
      chk("rvalid", reg_rvalid, 1'b1);
      chk("rdata", reg_rdata, e);
   endtask
   // ----
   // Scenarios
   // ----
   task automatic t_reset_vals;
      rc(ADDR_OP_MODE_COMP, 8'h00);
      rc(ADDR_OUTPUT_ON_OFF, PWR);
      rc(ADDR_PWM_PIN_SELECT, 8'h00);
      rc(ADDR_GATEWAY_CFG, 8'h00);
      rc(ADDR_GATEWAY_BASE, 8'h00);
      for (int i = 0; i < 8; i++)
         chk("level", pwm_level[8*i +: 8], PWR[i] ? ONL : OFFL);
   endtask
   task automatic t_pwm_and_outputs;
      wr(ADDR_PWM_PIN_SELECT, 8'h07);
      wr(ADDR_PWM_PIN_LEVEL, 8'hff);
      rc(ADDR_PWM_PIN_LEVEL, 8'hff);
      chk("pin7", pwm_level[63:56], 8'hff);
      wr(ADDR_PWM_PIN_SELECT, 8'h00);
      rc(ADDR_PWM_PIN_LEVEL, OFFL);
      wr(ADDR_OUTPUT_ON_OFF, 8'h51);
      @(negedge clk);
      chk("pin0", pwm_level[7:0], ONL);
      chk("pin1", pwm_level[15:8], OFFL);
      chk("pin6", pwm_level[55:48], OFFL);
      autolight_en = 1'b1;
      wr(ADDR_OUTPUT_ON_OFF, 8'h00);
      @(negedge clk);
      chk("pin0", pwm_level[7:0], ONL);
      autolight_en = 1'b0;
   endtask
   task automatic t_mode_comp;
      wr(ADDR_OP_MODE_COMP, 8'h01);
      chk("mode", op_mode, 2'h1);
      repeat (8) @(negedge clk);
      rc(ADDR_INTERRUPT_SOURCE, 8'h01);
      wr(ADDR_OP_MODE_COMP, 8'h03);
      chk("mode", op_mode, 2'h1);
      wr(ADDR_OP_MODE_COMP, 8'h05);
      rc(ADDR_OP_MODE_COMP, 8'h05);
      repeat (8) @(negedge clk);
      rc(ADDR_OP_MODE_COMP, 8'h01);
      rc(ADDR_INTERRUPT_SOURCE, 8'h03);
      wr(ADDR_OP_MODE_COMP, 8'h02);
      repeat (8) @(negedge clk);
      chk("mode", op_mode, 2'h2);
      rc(ADDR_INTERRUPT_SOURCE, 8'h00);
      wr(ADDR_OP_MODE_COMP, 8'h00);
      chk("mode", op_mode, 2'h0);
      repeat (8) @(negedge clk);
      rc(ADDR_INTERRUPT_SOURCE, 8'h01);
   endtask
   // Top block of the memory exercises the highest legal base.
   task automatic t_spm_block;
      wr(ADDR_GATEWAY_CFG, 8'h10);
      wr(ADDR_GATEWAY_BASE, 8'h78);
      for (int i = 0; i < 8; i++)
         wr(8'(i), 8'ha0 + 8'(i));
      wr(ADDR_GATEWAY_CFG, 8'h00);
      repeat (3) @(negedge clk);
      chk("irq_n", irq_n, 1'b0);
      chk("src5", interrupt_source[5], 1'b1);
      chk("done", write_done, 1'b1);
      for (int i = 0; i < 8; i++)
         chk("mem", pm.mem[120 + i], 8'ha0 + 8'(i));
      rc(ADDR_PWM_PIN_SELECT, 8'h00);
      chk("done", write_done, 1'b0);
      chk("irq_n", irq_n, 1'b1);
      wr(ADDR_GATEWAY_CFG, 8'h18);
      wr(ADDR_GATEWAY_BASE, 8'h7d);
      rc(ADDR_GATEWAY_BASE, 8'h78);
      for (int i = 0; i < 8; i++)
         rc(8'(i), 8'ha0 + 8'(i));
      wr(ADDR_GATEWAY_CFG, 8'h10);
      wr(ADDR_GATEWAY_BASE, 8'h00);
      for (int i = 0; i < 3; i++)
         wr(8'(i), 8'h33);
      wr(ADDR_GATEWAY_CFG, 8'hc7);
      repeat (3) @(negedge clk);
      chk("done", write_done, 1'b0);
      rc(ADDR_GATEWAY_CFG, 8'h00);
   endtask
   task automatic t_keys;
      wr(ADDR_KEY_HI, 8'h62);
      wr(ADDR_KEY_LO, 8'h9d);
      @(negedge clk);
      chk("unlock", burn_unlocked, 1'b1);
      wr(ADDR_KEY_LO, 8'h00);
      @(negedge clk);
      chk("unlock", burn_unlocked, 1'b0);
      wr(ADDR_CHIP_RESET, 8'hde);
      wr(ADDR_PWM_PIN_SELECT, 8'h00);
      wr(ADDR_CHIP_RESET, 8'h00);
      chk("chip_reset", chip_reset, 1'b0);
      @(negedge clk);
      reg_wr = 1'b1;
      reg_addr = ADDR_CHIP_RESET;
      reg_wdata = 8'hde;
      @(negedge clk);
      reg_wdata = 8'h00;
      @(negedge clk);
      reg_wr = 1'b0;
      chk("chip_reset", chip_reset, 1'b1);
   endtask
   task automatic finish_test;
      if (err_total == 0 && checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   initial begin
      repeat (6) @(negedge clk);
      srst = 1'b0;
      t_reset_vals;
      t_pwm_and_outputs;
      t_mode_comp;
      t_spm_block;
      t_keys;
      finish_test;
   end
   // The scenarios need well under a thousand cycles.
   initial begin
      #(100 * 4000);
      err_total++;
      finish_test;
   end
endmodule
